// [hw/pri_params.svh]
/*
  Constants of the priority interrupt unit: register offsets, field positions,
  reset values, instruction codes, fixed addresses and timing figures.
  Assumes inclusion by bare name before the package and the design modules.
*/
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH
`define PRI_ADDR_CTRL     12'h000
`define PRI_ADDR_IOT      12'h004
`define PRI_ADDR_STATUS   12'h008
`define PRI_ADDR_VECTOR   12'h00C
`define PRI_CTRL_API_EN   0
`define PRI_CTRL_PI_EN    1
`define PRI_CTRL_LOCK     2
`define PRI_CTRL_CLKSW    3
`define PRI_CTRL_SW_LSB   4
`define PRI_CTRL_RESET    4'h0
`define PRI_IOT_CLK_SKIP  18'h38001
`define PRI_IOT_CLK_OFF   18'h38004
`define PRI_IOT_CLK_ON    18'h38024
`define PRI_IOT_PF_SKIP   18'h38C81
`define PRI_IOT_DEBREAK   18'h386C4
`define PRI_IOT_DEBREAK_R 18'h386E4
`define PRI_RTC_ADDR      15'h0007
`define PRI_RESTART_ADDR  15'h0000
`define PRI_ENTRY_BASE    7'h20
`define PRI_CH_CLK        9
`define PRI_CH_PF         10
`define PRI_HW_MASK       32'hFFFFF9F0
`define PRI_LVL_PI        3
`define PRI_LVL_CAL       4
`define PRI_BURST_US      250
`define PRI_CLK_MHZ       125
`define PRI_BURST_CYC     (`PRI_BURST_US * `PRI_CLK_MHZ)
`define PRI_PULSE_CYC     32
`endif

// [hw/pri_pkg.sv]
/*
  Types and decode functions of the priority interrupt unit.
  Assumes pri_params.svh is on the include path.
*/
`default_nettype none
`include "pri_params.svh"
package pri_pkg;
  typedef struct packed {
    logic t1;
    logic t3;
    logic t4;
  } pri_iop_t;

  typedef enum logic [2:0] {
    GR_IDLE = 3'b001,
    GR_SYNC = 3'b010,
    GR_HOLD = 3'b100
  } pri_grant_st_t;

  typedef enum logic [3:0] {
    PF_RUN   = 4'b0001,
    PF_WAIT  = 4'b0010,
    PF_DOWN  = 4'b0100,
    PF_BURST = 4'b1000
  } pri_pwr_st_t;

  // level of each channel; unassigned channels sit on level 3
  function automatic logic [2:0] pri_chan_level(input logic [4:0] ch);
    case (ch)
      5'd0, 5'd1, 5'd2, 5'd3:                 pri_chan_level = 3'd4 + ch[2:0];
      5'd4, 5'd5, 5'd6, 5'd7, 5'd19, 5'd20, 5'd30: pri_chan_level = 3'd1;
      5'd8, 5'd12, 5'd13, 5'd18, 5'd21, 5'd31: pri_chan_level = 3'd2;
      5'd10, 5'd11, 5'd15:                    pri_chan_level = 3'd0;
      default:                                pri_chan_level = 3'd3;
    endcase
  endfunction : pri_chan_level

  // lowest set bit of an 8-bit level vector, 8 when none
  function automatic logic [3:0] pri_first_level(input logic [7:0] v);
    pri_first_level = 4'd8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) pri_first_level = 4'(i);
    end
  endfunction : pri_first_level
endpackage : pri_pkg
`default_nettype wire

// [hw/pri_rtc.sv]
/*
  Real-time clock request logic: enable flop, request flop, data-channel
  increment of the counter word and the overflow flag.
  Assumes the memory side performs the increment and reports the carry.
*/
`default_nettype none
`include "pri_params.svh"
module pri_rtc (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        iop_t1,
  input  wire logic        lock,
  input  wire logic        clk_switch,
  input  wire logic        clk_on,
  input  wire logic        clk_off,
  input  wire logic        dch_ack,
  input  wire logic        dch_carry,
  output logic             clk_en,
  output logic             clk_flag,
  output logic             dch_req,
  output logic [14:0]      dch_addr
);
  import pri_pkg::*;
  logic req_reg;
  logic tick_ok;

  assign tick_ok  = tick & clk_en & (lock | clk_switch);
  assign dch_addr = `PRI_RTC_ADDR;

  ////////////////////////////////////////////////////////////////////////
  // enable flop set by clock-on, cleared by clock-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clk_en <= 1'b0;
    else if (clk_on) clk_en <= 1'b1;
    else if (clk_off) clk_en <= 1'b0;
  end

  // request flop, handed to the data channel at time 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req_reg <= 1'b0;
    else req_reg <= tick_ok | (req_reg & ~(iop_t1 & ~dch_req));
  end

  // data-channel increment request held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dch_req <= 1'b0;
    else if (iop_t1 & req_reg & ~dch_req) dch_req <= 1'b1;
    else if (dch_ack) dch_req <= 1'b0;
  end

  // overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clk_flag <= 1'b0;
    else if (dch_req & dch_ack & dch_carry) clk_flag <= 1'b1;
    else if (clk_on | clk_off) clk_flag <= 1'b0;
  end
endmodule : pri_rtc
`default_nettype wire

// [hw/pri_pwr.sv]
/*
  Power-fail sequencer: run clear, internal reset pulse train, restore burst,
  power-fail flag and restart at location 0.
  Assumes power_low and power_ok are synchronous levels from the monitor.
*/
`default_nettype none
`include "pri_params.svh"
module pri_pwr #(
  parameter int BURST_CYC = `PRI_BURST_CYC,
  parameter int PULSE_CYC = `PRI_PULSE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        power_low,
  input  wire logic        power_ok,
  input  wire logic        lock,
  input  wire logic        instr_end,
  output logic             run_clear,
  output logic             int_reset,
  output logic             pf_flag,
  output logic             restart_req,
  output logic [14:0]      restart_addr
);
  import pri_pkg::*;
  localparam int BW = $clog2(BURST_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);
  pri_pwr_st_t    st_reg;
  logic [BW-1:0]  burst_reg;
  logic [PW-1:0]  pulse_reg;
  logic           pulsing;

  assign restart_addr = `PRI_RESTART_ADDR;
  assign pulsing = (st_reg == PF_BURST) | ((st_reg == PF_DOWN) & ~pf_flag);

  ////////////////////////////////////////////////////////////////////////
  // sequence of fail, hold-down and restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= PF_RUN;
    else begin
      case (st_reg)
        PF_RUN:   if (power_low) st_reg <= lock ? PF_DOWN : PF_WAIT;
        PF_WAIT:  if (instr_end) st_reg <= PF_DOWN;
        PF_DOWN:  if (power_ok & ~power_low) st_reg <= PF_BURST;
        PF_BURST: if (burst_reg == BW'(BURST_CYC - 1)) st_reg <= PF_RUN;
        default:  st_reg <= PF_RUN;
      endcase
    end
  end

  // burst length counted from power good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) burst_reg <= '0;
    else if (st_reg == PF_BURST) burst_reg <= burst_reg + BW'(1);
    else burst_reg <= '0;
  end

  // repeating reset pulse, one cycle in every period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= '0;
      int_reset <= 1'b0;
    end else begin
      pulse_reg <= (pulsing && pulse_reg != PW'(PULSE_CYC - 1)) ? pulse_reg + PW'(1) : '0;
      int_reset <= pulsing & (pulse_reg == '0);
    end
  end

  // run clear at the end of the instruction in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_clear <= 1'b0;
    else run_clear <= (st_reg == PF_WAIT) & instr_end;
  end

  // flag of a handled failure and restart once the burst ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_flag     <= 1'b0;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (st_reg == PF_RUN && power_low && lock) pf_flag <= 1'b1;
      else if (st_reg == PF_BURST && burst_reg == BW'(BURST_CYC - 1)) begin
        restart_req <= pf_flag;
        pf_flag     <= 1'b0;
      end
    end
  end
endmodule : pri_pwr
`default_nettype wire

// [hw/pri_top.sv]
/*
  Eight-level priority interrupt unit with 32 channels, APB register access,
  clock and power-fail options. Instructions are delivered by APB writes.
  Assumes I/O processor time pulses t1, t3, t4 each one cycle wide, in order.
*/
`default_nettype none
`include "pri_params.svh"
module pri_top #(
  parameter int BURST_CYC = `PRI_BURST_CYC,
  parameter int PULSE_CYC = `PRI_PULSE_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire pri_pkg::pri_iop_t iop_time,
  input  wire logic              cpu_ready,
  input  wire logic [31:0]       ext_req,
  input  wire logic              pi_break,
  input  wire logic              cal_exec,
  input  wire logic              instr_end,
  input  wire logic              clk_tick,
  input  wire logic              dch_ack,
  input  wire logic              dch_carry,
  input  wire logic              power_low,
  input  wire logic              power_ok,
  output logic                   cp_api_req,
  output logic                   pi_inhibit,
  output logic                   pi_req,
  output logic                   api_grant,
  output logic [6:0]             api_vector,
  output logic                   dch_req,
  output logic [14:0]            dch_addr,
  output logic                   run_clear,
  output logic                   int_reset,
  output logic                   restart_req,
  output logic [14:0]            restart_addr
);
  import pri_pkg::*;

  logic [3:0]    ctrl_reg;
  logic [3:0]    sw_req_reg;
  logic          skip_reg;
  logic [31:0]   rq_reg;
  logic [7:0]    active_reg;
  logic [4:0]    sel_ch_reg;
  pri_grant_st_t gr_reg;
  logic [31:0]   src;
  logic [31:0]   elig;
  logic [3:0]    min_act;
  logic [4:0]    pick_ch;
  logic [2:0]    sel_lvl;
  logic          api_en;
  logic          pi_en;
  logic          lock;
  logic          apb_wr;
  logic          apb_rd;
  logic          iot_wr;
  logic [17:0]   iot_code;
  logic          clk_on;
  logic          clk_off;
  logic          clk_en;
  logic          clk_flag;
  logic          pf_flag;
  logic          pf_api;
  logic          debreak;
  logic          grant_done;
  logic [31:0]   rd_mux;
  logic          addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write takes effect on the pready edge
  assign apb_wr   = psel & penable & pready & pwrite;
  assign apb_rd   = psel & penable & ~pready & ~pwrite;
  assign addr_ok  = (paddr == `PRI_ADDR_CTRL) | (paddr == `PRI_ADDR_IOT) |
                    (paddr == `PRI_ADDR_STATUS) | (paddr == `PRI_ADDR_VECTOR);
  assign api_en   = ctrl_reg[`PRI_CTRL_API_EN];
  assign pi_en    = ctrl_reg[`PRI_CTRL_PI_EN];
  assign lock     = ctrl_reg[`PRI_CTRL_LOCK];

  // pready and error raised for exactly one cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
    end
  end

  // read data multiplexer; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      `PRI_ADDR_CTRL:   rd_mux = {24'h000000, sw_req_reg, ctrl_reg};
      `PRI_ADDR_IOT:    rd_mux = {31'h00000000, skip_reg};
      `PRI_ADDR_STATUS: rd_mux = {19'h00000, cp_api_req, (gr_reg != GR_IDLE), clk_en,
                                  pf_flag, clk_flag, active_reg};
      `PRI_ADDR_VECTOR: rd_mux = {19'h00000, sel_ch_reg, 1'b0, api_vector};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // read data captured when the answer is prepared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (apb_rd) prdata <= rd_mux;
  end

  // control bits: enables, console lock, console clock switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_reg <= `PRI_CTRL_RESET;
    else if (apb_wr && paddr == `PRI_ADDR_CTRL) ctrl_reg <= pwdata[3:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction decode on writes to the instruction register
  assign iot_wr   = apb_wr & (paddr == `PRI_ADDR_IOT);
  assign iot_code = pwdata[17:0];
  assign clk_on   = iot_wr & (iot_code == `PRI_IOT_CLK_ON);
  assign clk_off  = iot_wr & (iot_code == `PRI_IOT_CLK_OFF);
  assign debreak  = iot_wr & ((iot_code == `PRI_IOT_DEBREAK) |
                              (iot_code == `PRI_IOT_DEBREAK_R));

  // skip answer of the last instruction, read back by the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) skip_reg <= 1'b0;
    else if (iot_wr) begin
      case (iot_code)
        `PRI_IOT_CLK_SKIP: skip_reg <= clk_flag;
        `PRI_IOT_PF_SKIP:  skip_reg <= pf_flag;
        default:           skip_reg <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal options
  pri_rtc u_rtc (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (clk_tick),
    .iop_t1     (iop_time.t1),
    .lock       (lock),
    .clk_switch (ctrl_reg[`PRI_CTRL_CLKSW]),
    .clk_on     (clk_on),
    .clk_off    (clk_off),
    .dch_ack    (dch_ack),
    .dch_carry  (dch_carry),
    .clk_en     (clk_en),
    .clk_flag   (clk_flag),
    .dch_req    (dch_req),
    .dch_addr   (dch_addr)
  );

  pri_pwr #(
    .BURST_CYC (BURST_CYC),
    .PULSE_CYC (PULSE_CYC)
  ) u_pwr (
    .pclk         (pclk),
    .presetn      (presetn),
    .power_low    (power_low),
    .power_ok     (power_ok),
    .lock         (lock),
    .instr_end    (instr_end),
    .run_clear    (run_clear),
    .int_reset    (int_reset),
    .pf_flag      (pf_flag),
    .restart_req  (restart_req),
    .restart_addr (restart_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  // request sources: bus devices, software, clock and power fail
  assign pf_api = pf_flag & lock & api_en;
  always_comb begin
    src = ext_req & `PRI_HW_MASK;
    src[3:0] = sw_req_reg;
    src[`PRI_CH_CLK] = clk_flag;
    src[`PRI_CH_PF]  = pf_api;
  end

  // software requests: writing one requests, grant clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sw_req_reg <= 4'h0;
    else begin
      sw_req_reg <= (sw_req_reg & ~({3'b000, grant_done} << sel_ch_reg[1:0]
                                    & {4{sel_ch_reg[4:2] == 3'b000}})) |
                    ((apb_wr && paddr == `PRI_ADDR_CTRL) ? pwdata[7:4] : 4'h0);
    end
  end

  // channel request flops, loaded at time 4 while idle
  assign grant_done = (gr_reg == GR_HOLD) & iop_time.t4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rq_reg <= 32'h00000000;
    else if (iop_time.t4 && api_en && gr_reg == GR_IDLE) rq_reg <= src;
    else if (grant_done) rq_reg[sel_ch_reg] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // eligibility against the highest active level
  assign min_act = pri_first_level(active_reg);
  generate
    for (genvar g = 0; g < 32; g++) begin : g_elig
      assign elig[g] = rq_reg[g] & ({1'b0, pri_chan_level(5'(g))} < min_act);
    end
  endgenerate

  // choose the lowest level, then the first channel on it
  always_comb begin
    pick_ch = 5'd0;
    for (int lv = 7; lv >= 0; lv--) begin
      for (int c = 31; c >= 0; c--) begin
        if (elig[c] && pri_chan_level(5'(c)) == 3'(lv)) pick_ch = 5'(c);
      end
    end
  end

  assign cp_api_req = |elig;
  // hardware levels shut out the program interrupt
  always_comb begin
    pi_inhibit = 1'b0;
    for (int c = 0; c < 32; c++) begin
      if (elig[c] && pri_chan_level(5'(c)) < 3'd4) pi_inhibit = 1'b1;
    end
  end
  assign pi_req = pi_en & ~pi_inhibit & (active_reg[3:0] == 4'h0) &
                  (clk_flag | (pf_flag & lock & ~api_en));

  ////////////////////////////////////////////////////////////////////////
  // grant sequence: sync at t1, grant dropped at t3, level set at t4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gr_reg <= GR_IDLE;
    else begin
      case (gr_reg)
        GR_IDLE: if (iop_time.t1 & cp_api_req & cpu_ready) gr_reg <= GR_SYNC;
        GR_SYNC: if (iop_time.t3) gr_reg <= GR_HOLD;
        GR_HOLD: if (iop_time.t4) gr_reg <= GR_IDLE;
        default: gr_reg <= GR_IDLE;
      endcase
    end
  end

  // granted channel, grant line and entry address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ch_reg <= 5'd0;
      api_grant  <= 1'b0;
      api_vector <= 7'h00;
    end else if (gr_reg == GR_IDLE && iop_time.t1 && cp_api_req && cpu_ready) begin
      sel_ch_reg <= pick_ch;
      api_grant  <= 1'b1;
      api_vector <= `PRI_ENTRY_BASE + {2'b00, pick_ch};
    end else if (gr_reg == GR_SYNC && iop_time.t3) begin
      api_grant  <= 1'b0;
    end
  end

  // level active flops; sets win over a debreak in the same cycle
  assign sel_lvl = pri_chan_level(sel_ch_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) active_reg <= 8'h00;
    else begin
      active_reg <= (active_reg & ~((debreak && min_act < 4'd8) ? (8'h01 << min_act[2:0]) : 8'h00)) |
                    (grant_done ? (8'h01 << sel_lvl) : 8'h00) |
                    (pi_break ? (8'h01 << `PRI_LVL_PI) : 8'h00) |
                    ((cal_exec & api_en) ? (8'h01 << `PRI_LVL_CAL) : 8'h00);
    end
  end
endmodule : pri_top
`default_nettype wire

// [testbench/pri_chk.sv]
/* checker on the ports of pri_top
   assumes it is bound into every pri_top instance */
`default_nettype none
module pri_chk (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire pri_pkg::pri_iop_t iop_time,
  input wire logic              cp_api_req,
  input wire logic              cpu_ready,
  input wire logic              pi_inhibit,
  input wire logic              pi_req,
  input wire logic              api_grant,
  input wire logic [6:0]        api_vector,
  input wire logic              dch_req,
  input wire logic [14:0]       dch_addr,
  input wire logic [14:0]       restart_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import pri_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////
  // bus, grant sequence and fixed addresses
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_grant_t1: assert property ($rose(api_grant) |-> $past(iop_time.t1 && cp_api_req && cpu_ready))
    else $error("grant without t1");
  a_grant_t3: assert property (api_grant && iop_time.t3 |=> !api_grant) else $error("grant past t3");
  a_grant_holds: assert property (api_grant && !iop_time.t3 |=> api_grant) else $error("grant lost");
  a_vector_base: assert property (api_grant |-> api_vector[6:5] == 2'b01) else $error("bad vector");
  a_hw_over_pi: assert property (pi_inhibit |-> cp_api_req && !pi_req) else $error("pi not held");
  a_dch_sync: assert property ($rose(dch_req) |-> $past(iop_time.t1)) else $error("dch unsynced");
  a_fixed_addr: assert property (dch_addr == 15'h0007 && restart_addr == 15'h0000) else $error("addr");
endmodule : pri_chk
bind pri_top pri_chk u_chk (.*);
`default_nettype wire

// [testbench/pri_far.sv]
/* far side model: I/O processor time states and memory side of the clock bump
   assumes a free running pclk and the data-channel handshake of pri_top */
`default_nettype none
module pri_far (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          dch_req,
  output pri_pkg::pri_iop_t iop_time,
  output logic              dch_ack,
  output logic              dch_carry
);
  timeunit 1ns;
  timeprecision 1ps;
  import pri_pkg::*;
  logic [1:0]  ph;
  logic [1:0]  d;
  logic [17:0] word;
  //////////
  // time states t1, t3, t4, then one idle cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 2'h0;
      iop_time <= '0;
    end else begin
      ph <= ph + 2'h1;
      iop_time <= {ph == 2'h0, ph == 2'h1, ph == 2'h2};
    end
  end
  // memory word 7: bump two cycles into a request, carry on wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d <= 2'h0;
      word <= 18'h3FFFF; // first bump wraps
      dch_ack <= 1'b0;
      dch_carry <= 1'b0;
    end else begin
      d <= !dch_req ? 2'h0 : (d == 2'h3 ? d : d + 2'h1);
      dch_ack <= dch_req && d == 2'h2;
      dch_carry <= dch_req && d == 2'h2 && word == 18'h3FFFF;
      if (dch_req && d == 2'h2) word <= word + 18'h1;
    end
  end
endmodule : pri_far
`default_nettype wire

// [testbench/tb.sv]
/* bench of pri_top: apb master, scenarios, timeout and verdict
   assumes pri_far supplies time states and the memory side */
`default_nettype none
`include "pri_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pri_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, cpu_ready = 1;
  logic pi_break = 0, cal_exec = 0, instr_end = 0, clk_tick = 0, power_low = 0, power_ok = 1;
  logic pready, pslverr, cp_api_req, pi_inhibit, pi_req, api_grant, dch_req, dch_ack, dch_carry;
  logic run_clear, int_reset, restart_req;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, ext_req = '0, prdata, rd;
  logic [6:0] api_vector;
  logic [14:0] dch_addr, restart_addr;
  pri_iop_t iop_time;
  int failures = 0, n_checks = 0, cyc = 0;
  pri_top #(.BURST_CYC(40), .PULSE_CYC(4)) DUT (.*);
  pri_far far (.*);
  //////////
  always #4 pclk = ~pclk;
  // cycle ceiling for a hung run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic iot(input logic [17:0] c);
    apb(1, `PRI_ADDR_IOT, {14'h0, c});
  endtask : iot
  task automatic lvl(input logic [7:0] e);
    apb(0, `PRI_ADDR_STATUS, 0);
    chk(rd & 32'hFF, e);
  endtask : lvl
  task automatic grant(input logic [6:0] v);
    do @(posedge pclk); while (api_grant !== 1'b1);
    chk(api_vector, v);
    repeat (4) @(posedge pclk);
  endtask : grant
  // one-cycle pulse: 0 pi break, 1 system call, 2 instruction end, 3 tick
  task automatic pulse(input int s);
    @(posedge pclk);
    {pi_break, cal_exec, instr_end, clk_tick} <= 4'(4'b1000 >> s);
    @(posedge pclk);
    {pi_break, cal_exec, instr_end, clk_tick} <= 4'h0;
  endtask : pulse
  //////////
  task automatic t_reset();
    apb(0, `PRI_ADDR_CTRL, 0);
    chk(rd, 0);
    lvl(0);
    apb(0, 12'h010, 0);
    chk({rd[30:0], err}, 1);
  endtask : t_reset
  task automatic t_soft();
    apb(1, `PRI_ADDR_CTRL, 32'h21);
    grant(7'h21);
    apb(1, `PRI_ADDR_CTRL, 32'h51);
    grant(7'h20);
    lvl(8'h30);
    iot(`PRI_IOT_DEBREAK);
    iot(`PRI_IOT_DEBREAK_R);
    grant(7'h22);
    iot(`PRI_IOT_DEBREAK);
    lvl(0);
  endtask : t_soft
  task automatic t_ext();
    ext_req <= 32'h810;
    grant(7'h2B);
    ext_req <= 32'h10;
    iot(`PRI_IOT_DEBREAK);
    grant(7'h24);
    ext_req <= 0;
    iot(`PRI_IOT_DEBREAK);
    lvl(0);
  endtask : t_ext
  task automatic t_special();
    apb(1, `PRI_ADDR_CTRL, 0);
    pulse(0);
    lvl(8'h08);
    iot(`PRI_IOT_DEBREAK);
    apb(1, `PRI_ADDR_CTRL, 1);
    pulse(1);
    lvl(8'h10);
    iot(`PRI_IOT_DEBREAK);
  endtask : t_special
  task automatic t_clock();
    apb(1, `PRI_ADDR_CTRL, 32'h5);
    iot(`PRI_IOT_CLK_ON);
    pulse(3);
    grant(7'h29);
    iot(`PRI_IOT_CLK_SKIP);
    apb(0, `PRI_ADDR_IOT, 0);
    chk(rd[0], 1);
    iot(`PRI_IOT_CLK_OFF);
    iot(`PRI_IOT_CLK_SKIP);
    apb(0, `PRI_ADDR_IOT, 0);
    chk(rd[0], 0);
    iot(`PRI_IOT_DEBREAK);
    pulse(3);
    repeat (12) @(posedge pclk);
    chk(dch_req, 0);
  endtask : t_clock
  task automatic t_power();
    int n = 0;
    int k = 0;
    apb(1, `PRI_ADDR_CTRL, 32'h5);
    power_low <= 1;
    power_ok <= 0;
    grant(7'h2A);
    iot(`PRI_IOT_PF_SKIP);
    apb(0, `PRI_ADDR_IOT, 0);
    chk(rd[0], 1);
    iot(`PRI_IOT_DEBREAK);
    power_low <= 0;
    power_ok <= 1;
    do begin
      @(posedge pclk);
      n++;
      k += (int_reset === 1'b1);
    end while (restart_req !== 1'b1);
    chk({n >= 40, k > 0, restart_addr}, {2'b11, 15'h0});
    apb(1, `PRI_ADDR_CTRL, 32'h1);
    power_low <= 1;
    power_ok <= 0;
    pulse(2);
    do @(posedge pclk); while (run_clear !== 1'b1);
    k = 0;
    repeat (12) begin
      @(posedge pclk);
      k += (int_reset === 1'b1);
    end
    chk(k >= 2, 1);
  endtask : t_power
  //////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_soft();
    t_ext();
    t_special();
    t_clock();
    t_power();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
